// File: tb/fscr_regs_assertions.sv
// concurrent checks on the fiber control and status register pair
`timescale 1ns/10ps

module fscr_regs_assertions #(
  parameter int RST_CYCLES = 25
) (
  input wire logic SYS_CLK_I, // clock
  input wire logic SYS_RST_I, // reset
  input wire logic [11:0] ADDR_I, // address
  input wire logic [15:0] WR_DATA_I, // write data
  input wire logic WR_EN_I, // write strobe
  input wire logic RD_EN_I, // read strobe
  input wire logic [15:0] RD_DATA_O, // read data
  input wire logic [2:0] PATH_SEL_I, // path code
  input wire logic BRIDGE_S2R_I, // bridge direction
  input wire logic MII_SEL_I, // mii side
  input wire fscr_pkg::fscr_link_t LINK_I, // path status
  input wire logic TX_EN_I, // transmit enable
  input wire logic FIBER_RST_O, // fiber reset
  input wire logic LOOPBACK_O, // loopback
  input wire logic SERIAL_FORCE_SPEED_O, // forced speed
  input wire logic AN_ENABLE_O, // autoneg on
  input wire logic AN_RESTART_O, // restart pulse
  input wire logic POWER_DOWN_O, // power down
  input wire logic ISOLATE_O, // isolate
  input wire logic FULL_DUPLEX_O, // duplex
  input wire logic COLLISION_O // collision
);
  // ------------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------------
  logic [8:0] hold_reg;

  // length of each fiber reset pulse, so the hold time is checked exactly
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I || !FIBER_RST_O)
    begin
      hold_reg <= 9'h000;
    end
    else
    begin
      hold_reg <= hold_reg + 9'h001;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  chk_status_fixed: assert property (RD_EN_I && ADDR_I == 12'hc01 |=>
    (RD_DATA_O & 16'hffcb) == 16'h6149)
    else $error("status fixed bits wrong");
  chk_status_live: assert property (RD_EN_I && ADDR_I == 12'hc01 |=>
    RD_DATA_O[5:4] == {$past(LINK_I.autoneg_done), $past(LINK_I.far_fault)})
    else $error("status live bits wrong");
  chk_read_quiet: assert property (!RD_EN_I || ADDR_I[11:1] != 11'h600 |=> RD_DATA_O == 16'h0000)
    else $error("read data outside a mapped read");
  chk_reset_start: assert property (WR_EN_I && ADDR_I == 12'hc00 && WR_DATA_I[15]
    && !FIBER_RST_O && !$past(FIBER_RST_O) |=> FIBER_RST_O)
    else $error("soft reset did not start");
  chk_reset_hold: assert property ($fell(FIBER_RST_O) && !$past(POWER_DOWN_O) |-> hold_reg == RST_CYCLES)
    else $error("soft reset hold length wrong");
  chk_pd_holds: assert property (POWER_DOWN_O |-> FIBER_RST_O)
    else $error("power down without fiber reset");
  chk_loop_path: assert property (LOOPBACK_O |-> $past(PATH_SEL_I) inside {3'h1, 3'h2, 3'h3})
    else $error("loopback on wrong path");
  chk_iso_path: assert property (ISOLATE_O |-> $past(PATH_SEL_I) inside {3'h1, 3'h2, 3'h3}
    && !($past(PATH_SEL_I) == 3'h3 && $past(BRIDGE_S2R_I)))
    else $error("isolate on wrong path");
  chk_an_path: assert property (AN_ENABLE_O |-> $past(PATH_SEL_I) inside {3'h1, 3'h3, 3'h4}
    && !SERIAL_FORCE_SPEED_O)
    else $error("autoneg enable on wrong path");
  chk_force_path: assert property (SERIAL_FORCE_SPEED_O |-> $past(PATH_SEL_I) inside {3'h3, 3'h6})
    else $error("forced speed on wrong path");
  chk_half_duplex: assert property (!FULL_DUPLEX_O |-> $past(PATH_SEL_I) == 3'h2 && $past(MII_SEL_I))
    else $error("half duplex outside mii path");
  chk_col_cause: assert property (COLLISION_O |-> $past(TX_EN_I))
    else $error("collision without transmit enable");
  chk_restart_pulse: assert property ($rose(AN_RESTART_O) |-> $past(WR_EN_I, 2)
    && $past(ADDR_I, 2) == 12'hc00 && $past(WR_DATA_I[9], 2) ##1 !AN_RESTART_O)
    else $error("restart pulse wrong");

  // main scenarios reached
  cov_soft_reset: cover property (FIBER_RST_O ##1 !FIBER_RST_O);
  cov_restart: cover property (AN_RESTART_O);
  cov_collision: cover property (COLLISION_O);
  cov_half: cover property (!FULL_DUPLEX_O);
endmodule

// File: tb/test_fscr_regs.sv
// self-checking bench for the fiber control and status register pair
`timescale 1ns/10ps

bind fscr_regs fscr_regs_assertions #(.RST_CYCLES(RST_CYCLES)) fscr_regs_assertions_i (
  .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I),
  .WR_EN_I(WR_EN_I), .RD_EN_I(RD_EN_I), .RD_DATA_O(RD_DATA_O), .PATH_SEL_I(PATH_SEL_I),
  .BRIDGE_S2R_I(BRIDGE_S2R_I), .MII_SEL_I(MII_SEL_I), .LINK_I(LINK_I), .TX_EN_I(TX_EN_I),
  .FIBER_RST_O(FIBER_RST_O), .LOOPBACK_O(LOOPBACK_O), .SERIAL_FORCE_SPEED_O(SERIAL_FORCE_SPEED_O),
  .AN_ENABLE_O(AN_ENABLE_O), .AN_RESTART_O(AN_RESTART_O), .POWER_DOWN_O(POWER_DOWN_O),
  .ISOLATE_O(ISOLATE_O), .FULL_DUPLEX_O(FULL_DUPLEX_O), .COLLISION_O(COLLISION_O)
);

module test_fscr_regs;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam int RST_N = 2; // short hold keeps the run brief
  typedef struct packed {
    logic [2:0] path;
    logic s2r;
    logic mii;
    logic [15:0] ctrl;
    fscr_pkg::fscr_link_t link;
    logic lk;
    logic [8:0] outs;
  } fscr_row_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [2:0] path = 3'h0;
  logic s2r = 1'h0;
  logic mii = 1'h0;
  fscr_pkg::fscr_strap_t strap = 3'h4; // speed low strapped, autoneg off
  fscr_pkg::fscr_link_t link = 6'h00;
  logic tx_en = 1'h0;
  wire [15:0] rdata;
  wire [8:0] outs; // reset, loop, speed, force, an, pd, iso, duplex
  wire an_rst;
  wire col;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  fscr_row_t rows [11];

  fscr_regs #(.RST_CYCLES(RST_N)) fscr_regs_i (
    .SYS_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WR_DATA_I(wdata), .WR_EN_I(wr), .RD_EN_I(rd),
    .RD_DATA_O(rdata), .PATH_SEL_I(path), .BRIDGE_S2R_I(s2r), .MII_SEL_I(mii), .STRAP_I(strap),
    .LINK_I(link), .TX_EN_I(tx_en), .FIBER_RST_O(outs[8]), .LOOPBACK_O(outs[7]), .SPEED_O(outs[6:5]),
    .SERIAL_FORCE_SPEED_O(outs[4]), .AN_ENABLE_O(outs[3]), .AN_RESTART_O(an_rst),
    .POWER_DOWN_O(outs[2]), .ISOLATE_O(outs[1]), .FULL_DUPLEX_O(outs[0]), .COLLISION_O(col)
  );

  // 250 MHz clock
  always #2 clk = ~clk;

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // bus write: one strobe cycle, released on the sampling edge
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  // bus read: data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    check(rdata, e);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    rows = '{
      '{3'h1, 1'h0, 1'h0, 16'h547f, 6'h24, 1'h1, 9'h0cb},
      '{3'h3, 1'h1, 1'h0, 16'h243f, 6'h1e, 1'h0, 9'h031},
      '{3'h3, 1'h0, 1'h0, 16'h5400, 6'h02, 1'h0, 9'h08b},
      '{3'h3, 1'h0, 1'h0, 16'h0000, 6'h02, 1'h1, 9'h011},
      '{3'h2, 1'h0, 1'h1, 16'h0000, 6'h08, 1'h1, 9'h000},
      '{3'h2, 1'h0, 1'h0, 16'h003f, 6'h04, 1'h0, 9'h001},
      '{3'h6, 1'h0, 1'h0, 16'h4440, 6'h3f, 1'h0, 9'h051},
      '{3'h5, 1'h0, 1'h0, 16'h0800, 6'h08, 1'h1, 9'h105},
      '{3'h0, 1'h0, 1'h0, 16'h3440, 6'h3f, 1'h0, 9'h061},
      '{3'h4, 1'h0, 1'h0, 16'h1000, 6'h04, 1'h1, 9'h009},
      '{3'h7, 1'h0, 1'h0, 16'h5400, 6'h3f, 1'h0, 9'h001}
    };
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    tick(3);
    check({7'h00, outs}, 16'h0021);
    rd_reg(12'hc00, 16'h2100);
    rd_reg(12'hc01, 16'h6149);
    // table of path and control settings
    foreach (rows[i])
    begin
      @(posedge clk);
      path <= rows[i].path;
      s2r <= rows[i].s2r;
      mii <= rows[i].mii;
      link <= rows[i].link;
      wr_reg(12'hc00, rows[i].ctrl);
      tick(2);
      check({7'h00, outs}, {7'h00, rows[i].outs});
      rd_reg(12'hc00, rows[i].ctrl & 16'h7dc0);
      rd_reg(12'hc01, 16'h6149 | {10'h000, rows[i].link.autoneg_done, rows[i].link.far_fault,
        1'h0, rows[i].lk, 2'h0});
    end
    // second reset with autoneg and speed high strapped
    @(posedge clk);
    strap <= 3'h3;
    rst <= 1'h1;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    tick(3);
    rd_reg(12'hc00, 16'h1140);
    // soft reset: hold length, self clear, other bits kept
    @(posedge clk);
    path <= 3'h1;
    link <= 6'h00;
    wr_reg(12'hc00, 16'h9000);
    #1;
    n = 0;
    while (outs[8] === 1'h1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 20)
      begin
        bad_count++;
        complete_run();
      end
    end
    check(16'(n), 16'(RST_N));
    rd_reg(12'hc00, 16'h1000);
    // restart pulse on every path code
    for (int p = 0; p < 8; p++)
    begin
      @(posedge clk);
      path <= 3'(p);
      wr_reg(12'hc00, 16'h0200);
      tick(1);
      check({15'h0000, an_rst}, {15'h0000, p inside {1, 3, 4, 6}});
      tick(1);
      check({15'h0000, an_rst}, 16'h0000);
    end
    rd_reg(12'hc00, 16'h0000);
    // collision test on and off
    for (int c = 0; c < 2; c++)
    begin
      wr_reg(12'hc00, c == 0 ? 16'h0080 : 16'h0000);
      @(posedge clk);
      tx_en <= 1'h1;
      @(posedge clk);
      tx_en <= 1'h0;
      #1;
      check({15'h0000, col}, c == 0 ? 16'h0001 : 16'h0000);
    end
    // read-only and unmapped places leave the pair untouched
    wr_reg(12'hc01, 16'hffff);
    wr_reg(12'hc02, 16'hffff);
    rd_reg(12'hc01, 16'h6149);
    rd_reg(12'hc02, 16'h0000);
    rd_reg(12'hc00, 16'h0000);
    complete_run();
  end
endmodule

// File: verilog/fscr_pkg.sv
// shared constants and types of the fiber control and status register pair
package fscr_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam logic [11:0] FIBER_CONTROL_ADDR = 12'hc00;
  localparam logic [11:0] FIBER_STATUS_ADDR = 12'hc01;

  // ------------------------------------------------------------------
  // control word fields
  // ------------------------------------------------------------------
  localparam int CTRL_SOFT_RESET_BIT = 15;
  localparam int CTRL_LOOPBACK_BIT = 14;
  localparam int CTRL_SPEED_LOW_BIT = 13;
  localparam int CTRL_AN_ENABLE_BIT = 12;
  localparam int CTRL_POWER_DOWN_BIT = 11;
  localparam int CTRL_ISOLATE_BIT = 10;
  localparam int CTRL_AN_RESTART_BIT = 9;
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int CTRL_COL_TEST_BIT = 7;
  localparam int CTRL_SPEED_HIGH_BIT = 6;
  localparam logic [15:0] FIBER_CONTROL_RESET = 16'h1140;
  // bits that software stores directly; 15 and 9 act, 5:0 are reserved
  localparam logic [15:0] CTRL_STORE_MASK = 16'h7dc0;

  // ------------------------------------------------------------------
  // status word fields
  // ------------------------------------------------------------------
  localparam int STS_AN_DONE_BIT = 5;
  localparam int STS_FAR_FAULT_BIT = 4;
  localparam int STS_LINK_BIT = 2;
  // fixed ability ones: 14, 13, 8, 6, 3, 0; all other fixed bits zero
  localparam logic [15:0] STS_FIXED_ONES = 16'h6149;

  // ------------------------------------------------------------------
  // speed codes
  // ------------------------------------------------------------------
  localparam logic [1:0] SPEED_10M = 2'h0;
  localparam logic [1:0] SPEED_100M = 2'h1;
  localparam logic [1:0] SPEED_1000M = 2'h2;
  localparam logic [1:0] SPEED_RSVD = 2'h3;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int FIBER_RST_NS = 100;
  localparam int FIBER_RST_CYCLES = (FIBER_RST_NS * CLK_MHZ + 999) / 1000;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    PATH_RGMII_COPPER = 3'h0,
    PATH_RGMII_1000X = 3'h1,
    PATH_RGMII_100FX = 3'h2,
    PATH_RGMII_SERIAL = 3'h3,
    PATH_MC_1000X = 3'h4,
    PATH_MC_100FX = 3'h5,
    PATH_SERIAL_COPPER = 3'h6,
    PATH_RSVD = 3'h7
  } fscr_path_t;

  typedef enum logic [1:0] {
    RST_IDLE = 2'b00,
    RST_HOLD = 2'b01,
    RST_DONE = 2'b11
  } fscr_rst_state_t;

  typedef struct packed {
    logic autoneg_done;
    logic far_fault;
    logic fx100_link;
    logic fx1000_link;
    logic serial_link;
    logic partner_link;
  } fscr_link_t;

  typedef struct packed {
    logic speed_select_low;
    logic speed_select_high;
    logic autoneg_enable;
  } fscr_strap_t;

endpackage

// File: verilog/fscr_regs.sv
// fiber and serial path control and status register pair
// ------------------------------------------------------------------
// Overview of operation
// - soft reset bit resets fiber, self-clears
// - bit 14 loops back MAC data
// - speed from bits 13 and 6, strapped
// - forced speed for serial only without autoneg
// - bit 12 enables autoneg, strap reset
// - bit 11 powers down, holds fiber reset
// - bit 10 isolates MAC, not serial-to-rgmii
// - bit 9 restarts autoneg, self-clears
// - bit 8 forces duplex in MII 100FX
// - collision test echoes transmit enable
// - status bits 14, 13 read one
// - status 15, 12-9, 1 read zero
// - status 8, 6, 3, 0 read one
// - status bit 5 shows autoneg done
// - status bit 4 shows remote fault
// - status bit 2 shows fiber link
// - rgmii-to-serial link needs partner under autoneg
// - serial-to-rgmii link follows partner
// - block shared from 0xC00 by all paths
// - three-bit path select chooses behaviour
// ------------------------------------------------------------------
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps

module fscr_regs #(
  parameter int RST_CYCLES = fscr_pkg::FIBER_RST_CYCLES
) (
  input wire logic SYS_CLK_I, // 250 MHz clock
  input wire logic SYS_RST_I, // synchronous reset, active high
  input wire logic [11:0] ADDR_I, // register address
  input wire logic [15:0] WR_DATA_I, // write data
  input wire logic WR_EN_I, // write strobe
  input wire logic RD_EN_I, // read strobe
  output logic [15:0] RD_DATA_O, // read data, cycle after strobe
  input wire logic [2:0] PATH_SEL_I, // operating path select
  input wire logic BRIDGE_S2R_I, // 1 = serial-to-rgmii bridge
  input wire logic MII_SEL_I, // 1 = MII on MAC side
  input wire fscr_pkg::fscr_strap_t STRAP_I, // strap pins, async
  input wire fscr_pkg::fscr_link_t LINK_I, // path status
  input wire logic TX_EN_I, // MAC transmit enable
  output logic FIBER_RST_O, // fiber logic held in reset
  output logic LOOPBACK_O, // MAC-side loopback
  output logic [1:0] SPEED_O, // selected link speed
  output logic SERIAL_FORCE_SPEED_O, // serial link uses SPEED_O
  output logic AN_ENABLE_O, // autoneg enabled
  output logic AN_RESTART_O, // one-cycle autoneg restart
  output logic POWER_DOWN_O, // serial link powered down
  output logic ISOLATE_O, // MAC interface isolated
  output logic FULL_DUPLEX_O, // duplex in use, 1 = full
  output logic COLLISION_O // collision indication
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  generate
    if (RST_CYCLES < 1 || RST_CYCLES > 255)
    begin : g_bad_rst
      $error("RST_CYCLES must lie in 1 to 255");
    end
  endgenerate

  // ------------------------------------------------------------------
  // path decoding helpers
  // ------------------------------------------------------------------
  // fiber paths, media converter modes included
  function automatic logic is_fiber(input fscr_pkg::fscr_path_t p);
    is_fiber = (p == fscr_pkg::PATH_RGMII_1000X) || (p == fscr_pkg::PATH_RGMII_100FX) ||
               (p == fscr_pkg::PATH_MC_1000X) || (p == fscr_pkg::PATH_MC_100FX);
  endfunction

  // paths running the serial link
  function automatic logic is_serial(input fscr_pkg::fscr_path_t p);
    is_serial = (p == fscr_pkg::PATH_RGMII_SERIAL) || (p == fscr_pkg::PATH_SERIAL_COPPER);
  endfunction

  // paths that run 1000BASE-X or serial autoneg
  function automatic logic is_an_path(input fscr_pkg::fscr_path_t p);
    is_an_path = (p == fscr_pkg::PATH_RGMII_1000X) || (p == fscr_pkg::PATH_MC_1000X) || is_serial(p);
  endfunction

  // ------------------------------------------------------------------
  // path state
  // ------------------------------------------------------------------
  fscr_pkg::fscr_path_t path;
  logic bridge_path;
  logic r2s_path;
  logic s2r_path;

  // reserved code 7 falls out of every group below
  assign path = fscr_pkg::fscr_path_t'(PATH_SEL_I);
  assign bridge_path = (path == fscr_pkg::PATH_RGMII_SERIAL);
  assign r2s_path = bridge_path && !BRIDGE_S2R_I;
  assign s2r_path = bridge_path && BRIDGE_S2R_I;

  // ------------------------------------------------------------------
  // strap synchroniser and capture
  // ------------------------------------------------------------------
  fscr_pkg::fscr_strap_t strap_meta_reg;
  fscr_pkg::fscr_strap_t strap_sync_reg;
  logic strap_load_reg;

  // straps are pins, so two flops before use
  always_ff @(posedge SYS_CLK_I)
  begin
    strap_meta_reg <= STRAP_I;
    strap_sync_reg <= strap_meta_reg;
  end

  // one-shot load in the first cycle after reset release
  always_ff @(posedge SYS_CLK_I)
  begin
    strap_load_reg <= SYS_RST_I;
  end

  // ------------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------------
  logic ctrl_wr;
  logic ctrl_rd;
  logic sts_rd;

  // both words sit at their printed offsets, shared by every path
  assign ctrl_wr = WR_EN_I && (ADDR_I == fscr_pkg::FIBER_CONTROL_ADDR);
  assign ctrl_rd = RD_EN_I && (ADDR_I == fscr_pkg::FIBER_CONTROL_ADDR);
  assign sts_rd = RD_EN_I && (ADDR_I == fscr_pkg::FIBER_STATUS_ADDR);

  // ------------------------------------------------------------------
  // stored control bits
  // ------------------------------------------------------------------
  logic [15:0] ctrl_reg;

  // bits 15 and 9 live in their own logic; reserved bits never stored
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      ctrl_reg <= fscr_pkg::FIBER_CONTROL_RESET & fscr_pkg::CTRL_STORE_MASK;
    else if (ctrl_wr)
      ctrl_reg <= WR_DATA_I & fscr_pkg::CTRL_STORE_MASK;
    else if (strap_load_reg)
    begin
      // a write in the load cycle wins over the straps
      ctrl_reg[fscr_pkg::CTRL_SPEED_LOW_BIT] <= strap_sync_reg.speed_select_low;
      ctrl_reg[fscr_pkg::CTRL_SPEED_HIGH_BIT] <= strap_sync_reg.speed_select_high;
      ctrl_reg[fscr_pkg::CTRL_AN_ENABLE_BIT] <= strap_sync_reg.autoneg_enable;
    end
  end

  // ------------------------------------------------------------------
  // soft reset sequencer
  // ------------------------------------------------------------------
  fscr_pkg::fscr_rst_state_t rst_state_reg;
  fscr_pkg::fscr_rst_state_t rst_state_next;
  logic [7:0] rst_cnt_reg;
  logic soft_rst_req;

  localparam logic [7:0] RST_LAST = 8'(RST_CYCLES - 1);

  assign soft_rst_req = ctrl_wr && WR_DATA_I[fscr_pkg::CTRL_SOFT_RESET_BIT];

  // hold for a fixed time, then release and clear the bit
  always_comb
  begin
    rst_state_next = rst_state_reg;
    unique case (rst_state_reg)
      fscr_pkg::RST_IDLE:
        if (soft_rst_req)
          rst_state_next = fscr_pkg::RST_HOLD;
      fscr_pkg::RST_HOLD:
        if (rst_cnt_reg == RST_LAST)
          rst_state_next = fscr_pkg::RST_DONE;
      fscr_pkg::RST_DONE:
        rst_state_next = fscr_pkg::RST_IDLE;
      default:
        rst_state_next = fscr_pkg::RST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      rst_state_reg <= fscr_pkg::RST_IDLE;
    else
      rst_state_reg <= rst_state_next;
  end

  // hold counter, restarted on entry
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I || rst_state_reg != fscr_pkg::RST_HOLD)
      rst_cnt_reg <= 8'h00;
    else
      rst_cnt_reg <= rst_cnt_reg + 8'h01;
  end

  // ------------------------------------------------------------------
  // autoneg restart
  // ------------------------------------------------------------------
  logic an_restart_reg;

  // only accepted on paths that negotiate; reads 1 for one cycle
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      an_restart_reg <= 1'b0;
    else
      an_restart_reg <= ctrl_wr && WR_DATA_I[fscr_pkg::CTRL_AN_RESTART_BIT] && is_an_path(path);
  end

  // ------------------------------------------------------------------
  // status word
  // ------------------------------------------------------------------
  logic link_now;
  logic [15:0] sts_word;
  logic [15:0] ctrl_word;

  // link source follows the active path
  always_comb
  begin
    link_now = 1'b0;
    if (path == fscr_pkg::PATH_RGMII_100FX || path == fscr_pkg::PATH_MC_100FX)
      link_now = LINK_I.fx100_link;
    else if (path == fscr_pkg::PATH_RGMII_1000X || path == fscr_pkg::PATH_MC_1000X)
      link_now = LINK_I.fx1000_link;
    else if (s2r_path)
      link_now = LINK_I.partner_link;
    else if (r2s_path && ctrl_reg[fscr_pkg::CTRL_AN_ENABLE_BIT])
      link_now = LINK_I.serial_link && LINK_I.partner_link;
    else if (r2s_path)
      link_now = LINK_I.serial_link;
  end

  // fixed ability bits, then live bits; all others stay zero
  always_comb
  begin
    sts_word = fscr_pkg::STS_FIXED_ONES;
    sts_word[fscr_pkg::STS_AN_DONE_BIT] = LINK_I.autoneg_done;
    sts_word[fscr_pkg::STS_FAR_FAULT_BIT] = LINK_I.far_fault;
    sts_word[fscr_pkg::STS_LINK_BIT] = link_now;
  end

  // control readback; self-clearing bits show their activity
  always_comb
  begin
    ctrl_word = ctrl_reg;
    ctrl_word[fscr_pkg::CTRL_SOFT_RESET_BIT] = (rst_state_reg != fscr_pkg::RST_IDLE);
    ctrl_word[fscr_pkg::CTRL_AN_RESTART_BIT] = an_restart_reg;
  end

  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------
  // data stand one cycle only; unmapped reads give zero
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      RD_DATA_O <= 16'h0000;
    else if (ctrl_rd)
      RD_DATA_O <= ctrl_word;
    else if (sts_rd)
      RD_DATA_O <= sts_word;
    else
      RD_DATA_O <= 16'h0000;
  end

  // ------------------------------------------------------------------
  // path controls
  // ------------------------------------------------------------------
  logic pd_active;
  logic an_en;

  assign pd_active = ctrl_reg[fscr_pkg::CTRL_POWER_DOWN_BIT] && (is_fiber(path) || bridge_path);
  assign an_en = ctrl_reg[fscr_pkg::CTRL_AN_ENABLE_BIT];

  // fiber digital held in reset by soft reset or power down
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      FIBER_RST_O <= 1'b0;
    else
      FIBER_RST_O <= (rst_state_next == fscr_pkg::RST_HOLD) || pd_active;
  end

  // power down only on paths with a serial or fiber link
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      POWER_DOWN_O <= 1'b0;
    else
      POWER_DOWN_O <= pd_active;
  end

  // loopback on rgmii 100FX, rgmii 1000X and both bridge directions
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      LOOPBACK_O <= 1'b0;
    else
      LOOPBACK_O <= ctrl_reg[fscr_pkg::CTRL_LOOPBACK_BIT] &&
                    (path == fscr_pkg::PATH_RGMII_1000X || path == fscr_pkg::PATH_RGMII_100FX ||
                     bridge_path);
  end

  // speed field; code 3 passed through, consumer treats as reserved
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      SPEED_O <= fscr_pkg::SPEED_1000M;
      SERIAL_FORCE_SPEED_O <= 1'b0;
    end
    else
    begin
      SPEED_O <= {ctrl_reg[fscr_pkg::CTRL_SPEED_HIGH_BIT], ctrl_reg[fscr_pkg::CTRL_SPEED_LOW_BIT]};
      SERIAL_FORCE_SPEED_O <= is_serial(path) && !an_en;
    end
  end

  // autoneg enable and restart pulse
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      AN_ENABLE_O <= 1'b0;
      AN_RESTART_O <= 1'b0;
    end
    else
    begin
      AN_ENABLE_O <= an_en && (path == fscr_pkg::PATH_RGMII_1000X || path == fscr_pkg::PATH_MC_1000X ||
                               bridge_path);
      AN_RESTART_O <= an_restart_reg;
    end
  end

  // isolate has no effect in serial-to-rgmii direction
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      ISOLATE_O <= 1'b0;
    else
      ISOLATE_O <= ctrl_reg[fscr_pkg::CTRL_ISOLATE_BIT] &&
                   (path == fscr_pkg::PATH_RGMII_1000X || path == fscr_pkg::PATH_RGMII_100FX ||
                    r2s_path);
  end

  // forced duplex only in MII 100FX, full duplex elsewhere
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      FULL_DUPLEX_O <= 1'b1;
    else if (path == fscr_pkg::PATH_RGMII_100FX && MII_SEL_I)
      FULL_DUPLEX_O <= ctrl_reg[fscr_pkg::CTRL_DUPLEX_BIT];
    else
      FULL_DUPLEX_O <= 1'b1;
  end

  // collision test mirrors transmit enable, one cycle late
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      COLLISION_O <= 1'b0;
    else
      COLLISION_O <= ctrl_reg[fscr_pkg::CTRL_COL_TEST_BIT] && TX_EN_I;
  end

endmodule
